// *** tie_table_indirect_exec.sv ***
// table indirect instruction executor with ahb-lite register access
// Operation
// [RQ1] one opcode byte selects a two-byte entry: jump, call or instruction.
// [RQ2] a jump loads pc from 4 or 5 low bits of byte one and byte two.
// [RQ3] a legacy call pushes pc and flags below sp and drops sp by four.
// [RQ4] an extended call pushes sp-6 to sp-2 and drops sp by 6, in 4 cycles.
// [RQ5] any other entry is executed and its own skip result is kept.
// [RQ6] the instruction takes 3 machine cycles, an extended call 4.
// [RQ7] five-location pushes only in extended mode, four only in legacy mode.
// [RQ8] port i/o code holds bank enable at 0 or 1 and bank select at 15.
// [RQ9] the bank select accepts only values 0, 1 and 15.
// [RQ10] both table bytes are fetched before any action is taken.
`timescale 1ns/1ns
`include "tie_map.svh"

module tie_table_indirect_exec
	import tie_pkg::*;
#(
	parameter int MC_CLKS = 4
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic [31:0]        hrdata,
	output logic               hresp,
	output tie_prog_req_t      prog_req,
	input  wire logic [7:0]    prog_rdata,
	output tie_stk_wr_t        stk_wr,
	output tie_exec_t          exec_out,
	input  wire logic          exec_skip,
	output logic               done
);

	// one machine cycle spans MC_CLKS clocks; four pushes must fit in it
	if (MC_CLKS < 4 || MC_CLKS > 16) begin : g_bad_mc_clks
		$error("MC_CLKS must lie between 4 and 16");
	end
	localparam logic [6:0] CLK_SHORT = 7'(`TIE_MC_SHORT * MC_CLKS);
	localparam logic [6:0] CLK_LONG  = 7'(`TIE_MC_LONG * MC_CLKS);
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_FLO   = 6'b000010,
		ST_FHI   = 6'b000100,
		ST_DEC   = 6'b001000,
		ST_PUSH  = 6'b010000,
		ST_WAIT  = 6'b100000
	} tie_state_t;
	tie_state_t    state_r;
	logic          ext_r;
	logic          pc13_r;
	logic          mbe_r;
	logic          rbe_r;
	logic [7:0]    taddr_r;
	logic [12:0]   pc_r;
	logic [7:0]    sp_r;
	logic [3:0]    mbs_r;
	logic [7:0]    byte0_r;
	logic [7:0]    byte1_r;
	tie_kind_t     kind_r;
	logic          skip_r;
	logic          done_flag_r;
	logic [6:0]    clk_cnt_r;
	logic [6:0]    clk_total_r;
	logic [2:0]    step_r;
	logic          wr_pend_r;
	logic [7:0]    wr_addr_r;
	logic [31:0]   wdata_lat;
	logic          start;
	logic          busy;
	logic          last_clk;
	logic [12:0]   target;
	logic [2:0]    push_cnt;
	logic          wr_ctrl;
	logic [11:0]   slot;

	// decode a register offset to its read value
	function automatic logic [31:0] rd_mux(input logic [7:0] ofs);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (ofs)
			`TIE_OFS_CTRL: begin
				v[`TIE_CTRL_EXT]  = ext_r;
				v[`TIE_CTRL_PC13] = pc13_r;
				v[`TIE_CTRL_MBE]  = mbe_r;
				v[`TIE_CTRL_RBE]  = rbe_r;
			end
			`TIE_OFS_TADDR:  v[7:0]  = taddr_r;
			`TIE_OFS_PC:     v[12:0] = pc_r;
			`TIE_OFS_SP:     v[7:0]  = sp_r;
			`TIE_OFS_MBS:    v[3:0]  = mbs_r;
			`TIE_OFS_STATUS: begin
				v[`TIE_ST_BUSY] = busy;
				v[`TIE_ST_KIND_HI:`TIE_ST_KIND_LO] = kind_r;
				v[`TIE_ST_SKIP] = skip_r;
				v[`TIE_ST_DONE] = done_flag_r;
			end
			`TIE_OFS_ENTRY:  v[15:0] = {byte0_r, byte1_r};
			default:         v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// one push slot: stack offset below sp, then the nibble written there
	// pc bit 12 reads as zero while the 12-bit counter is chosen
	function automatic logic [11:0] push_slot(input logic       ext,
	                                          input logic [2:0] step);
		logic [11:0] v;
		v = 12'h000;
		if (ext) begin
			unique case (step)
				3'd0:    v = {8'h06, pc_r[11:8]}; // see [RQ4]
				3'd1:    v = {8'h03, pc_r[7:4]};
				3'd2:    v = {8'h04, pc_r[3:0]};
				3'd3:    v = {8'h05, 3'b000, pc13_r & pc_r[12]};
				default: v = {8'h02, 2'b00, mbe_r, rbe_r};
			endcase
		end else begin
			unique case (step)
				3'd0:    v = {8'h04, pc_r[11:8]}; // see [RQ3]
				3'd1:    v = {8'h01, pc_r[7:4]};
				3'd2:    v = {8'h02, pc_r[3:0]};
				default: v = {8'h03, mbe_r, rbe_r, 1'b0, pc13_r & pc_r[12]};
			endcase
		end
		return v;
	endfunction
	assign busy     = (state_r != ST_IDLE);
	assign last_clk = (clk_cnt_r == clk_total_r - 7'd1);
	assign push_cnt = ext_r ? 3'(`TIE_PUSH_EXT)
	                        : 3'(`TIE_PUSH_LEGACY); // see [RQ7]
	always_comb slot = push_slot(ext_r, step_r);
	assign wdata_lat = hwdata;
	assign wr_ctrl  = wr_pend_r && (wr_addr_r == `TIE_OFS_CTRL);
	assign start    = wr_ctrl && wdata_lat[`TIE_CTRL_START] && !busy;

	// jump and call target: 4 or 5 bits of byte one above byte two
	assign target = pc13_r ? {byte0_r[4:0], byte1_r}
	                       : {1'b0, byte0_r[3:0], byte1_r}; // see [RQ2]

	// bus slave: zero wait, read data prepared in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_r <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				wr_pend_r <= hwrite;
				wr_addr_r <= haddr[7:0];
				if (!hwrite)
					hrdata <= (haddr[31:8] == 24'h000000) ?
					          rd_mux(haddr[7:0]) : 32'h0000_0000;
			end
		end
	end

	// control bits; held while an instruction is under way
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_r  <= 1'(`TIE_RST_CTRL >> `TIE_CTRL_EXT);
			pc13_r <= 1'(`TIE_RST_CTRL >> `TIE_CTRL_PC13);
			mbe_r  <= 1'(`TIE_RST_CTRL >> `TIE_CTRL_MBE);
			rbe_r  <= 1'(`TIE_RST_CTRL >> `TIE_CTRL_RBE);
		end else if (wr_ctrl && !busy) begin
			ext_r  <= wdata_lat[`TIE_CTRL_EXT];
			pc13_r <= wdata_lat[`TIE_CTRL_PC13];
			mbe_r  <= wdata_lat[`TIE_CTRL_MBE];
			rbe_r  <= wdata_lat[`TIE_CTRL_RBE];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			taddr_r <= 8'h00;
		else if (wr_pend_r && wr_addr_r == `TIE_OFS_TADDR && !busy)
			taddr_r <= wdata_lat[7:0];
	end

	// any other value is dropped, so the old bank stays selected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mbs_r <= `TIE_RST_MBS;
		else if (wr_pend_r && wr_addr_r == `TIE_OFS_MBS &&
		         (wdata_lat[3:0] == `TIE_MBS_BANK0 ||
		          wdata_lat[3:0] == `TIE_MBS_BANK1 ||
		          wdata_lat[3:0] == `TIE_MBS_BANK15)) // see [RQ9]
			mbs_r <= wdata_lat[3:0];
	end

	// sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= ST_IDLE;
			prog_req    <= '0;
			byte0_r     <= 8'h00;
			byte1_r     <= 8'h00;
			kind_r      <= TIE_KIND_NONE;
			step_r      <= 3'd0;
			clk_total_r <= CLK_SHORT;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start) begin
						prog_req.req  <= 1'b1; // see [RQ10]
						prog_req.addr <= {5'h00, taddr_r};
						clk_total_r   <= CLK_SHORT;
						state_r       <= ST_FLO;
					end
				end
				ST_FLO: begin
					prog_req.addr <= 13'({5'h00, taddr_r} + 13'd1); // see [RQ10]
					state_r       <= ST_FHI;
				end
				ST_FHI: begin
					prog_req.req <= 1'b0;
					byte0_r      <= prog_rdata;
					state_r      <= ST_DEC;
				end
				ST_DEC: begin
					byte1_r <= prog_rdata; // see [RQ1]
					step_r  <= 3'd0;
					if (byte0_r[7:5] == `TIE_KIND_JUMP) begin
						kind_r  <= TIE_KIND_JUMP;
						state_r <= ST_WAIT;
					end else if (byte0_r[7:5] == `TIE_KIND_CALL) begin
						kind_r  <= TIE_KIND_CALL;
						if (ext_r)
							clk_total_r <= CLK_LONG; // see [RQ6]
						state_r <= ST_PUSH;
					end else begin
						kind_r  <= TIE_KIND_INSTR; // see [RQ5]
						state_r <= ST_WAIT;
					end
				end
				ST_PUSH: begin
					step_r <= 3'(step_r + 3'd1);
					if (step_r == push_cnt - 3'd1)
						state_r <= ST_WAIT;
				end
				ST_WAIT: begin
					if (last_clk)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// machine cycle timing, counted in clocks from the start write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			clk_cnt_r <= 7'd0;
		else if (!busy)
			clk_cnt_r <= 7'd0;
		else
			clk_cnt_r <= 7'(clk_cnt_r + 7'd1); // see [RQ6]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done <= 1'b0;
		else
			done <= (state_r == ST_WAIT) && last_clk; // see [RQ6]
	end
	// stack port, one nibble per clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stk_wr <= '0;
		end else begin
			stk_wr.we <= (state_r == ST_PUSH);
			if (state_r == ST_PUSH) begin
				stk_wr.addr <= 8'(sp_r - slot[11:4]);
				stk_wr.data <= slot[3:0];
			end
		end
	end

	// pc: a jump loads after decode, once byte two is held
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pc_r <= `TIE_RST_PC;
		else if (state_r == ST_WAIT && kind_r == TIE_KIND_JUMP)
			pc_r <= target; // see [RQ2]
		else if (state_r == ST_PUSH && step_r == push_cnt - 3'd1)
			pc_r <= target; // see [RQ3] [RQ4]
		else if (wr_pend_r && wr_addr_r == `TIE_OFS_PC && !busy)
			pc_r <= wdata_lat[12:0];
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sp_r <= `TIE_RST_SP;
		else if (state_r == ST_PUSH && step_r == push_cnt - 3'd1)
			sp_r <= ext_r ? 8'(sp_r - `TIE_SP_DEC_EXT)
			              : 8'(sp_r - `TIE_SP_DEC_LEGACY); // see [RQ7]
		else if (wr_pend_r && wr_addr_r == `TIE_OFS_SP && !busy)
			sp_r <= wdata_lat[7:0];
	end

	// referenced instruction goes to the core; its skip verdict is kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			exec_out <= '0;
			skip_r   <= 1'b0;
		end else begin
			exec_out.valid <= (state_r == ST_DEC) &&
			                  byte0_r[7:5] != `TIE_KIND_JUMP &&
			                  byte0_r[7:5] != `TIE_KIND_CALL; // see [RQ5]
			if (state_r == ST_DEC)
				exec_out.code <= {byte0_r, prog_rdata};
			if (start)
				skip_r <= 1'b0;
			else if (state_r == ST_WAIT && kind_r == TIE_KIND_INSTR &&
			         exec_skip)
				skip_r <= 1'b1; // see [RQ5]
		end
	end

	// done flag: set wins over the clearing start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done_flag_r <= 1'b0;
		else if (state_r == ST_WAIT && last_clk)
			done_flag_r <= 1'b1;
		else if (start)
			done_flag_r <= 1'b0;
	end

endmodule

// *** tie_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef TIE_MAP_SVH
`define TIE_MAP_SVH

`define TIE_OFS_CTRL      8'h00
`define TIE_OFS_TADDR     8'h04
`define TIE_OFS_PC        8'h08
`define TIE_OFS_SP        8'h0c
`define TIE_OFS_MBS       8'h10
`define TIE_OFS_STATUS    8'h14
`define TIE_OFS_ENTRY     8'h18

`define TIE_CTRL_START    0
`define TIE_CTRL_EXT      1
`define TIE_CTRL_PC13     2
`define TIE_CTRL_MBE      3
`define TIE_CTRL_RBE      4

`define TIE_ST_BUSY       0
`define TIE_ST_KIND_LO    1
`define TIE_ST_KIND_HI    2
`define TIE_ST_SKIP       3
`define TIE_ST_DONE       4

`define TIE_RST_CTRL      5'h04
`define TIE_RST_PC        13'h0000
`define TIE_RST_SP        8'h00
`define TIE_RST_MBS       4'h0

`define TIE_KIND_JUMP     3'h0
`define TIE_KIND_CALL     3'h1

`define TIE_MC_SHORT      3
`define TIE_MC_LONG       4
`define TIE_PUSH_LEGACY   4
`define TIE_PUSH_EXT      5
`define TIE_SP_DEC_LEGACY 8'h04
`define TIE_SP_DEC_EXT    8'h06

`define TIE_MBS_BANK0     4'h0
`define TIE_MBS_BANK1     4'h1
`define TIE_MBS_BANK15    4'hf

`endif

// *** tie_pkg.sv ***
// types shared by the table indirect execution block
package tie_pkg;

	typedef enum logic [1:0] {
		TIE_KIND_NONE  = 2'h0,
		TIE_KIND_JUMP  = 2'h1,
		TIE_KIND_CALL  = 2'h2,
		TIE_KIND_INSTR = 2'h3
	} tie_kind_t;

	typedef struct packed {
		logic        req;
		logic [12:0] addr;
	} tie_prog_req_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [3:0] data;
	} tie_stk_wr_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] code;
	} tie_exec_t;

endpackage

// *** tie_table_indirect_exec_sva.sv ***
// port assertions for the table indirect executor
`timescale 1ns/1ns
module tie_chk
	import tie_pkg::*;
#(
	parameter int MC_CLKS = 4
) (
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire tie_prog_req_t prog_req,
	input wire tie_stk_wr_t   stk_wr,
	input wire tie_exec_t     exec_out,
	input wire logic          done
);
	// done pulses three or four machine cycles after the fetch starts
	localparam int LO = 3 * MC_CLKS;
	localparam int HI = 4 * MC_CLKS;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_push_walk;
		##1 stk_wr.addr == $past(stk_wr.addr) + 8'h03
		##1 stk_wr.addr == $past(stk_wr.addr) - 8'h01
		##1 stk_wr.addr == $past(stk_wr.addr) - 8'h01;
	endsequence
	sequence s_push_run;
		stk_wr.we [*4] ##1 (!stk_wr.we or (stk_wr.we ##1 !stk_wr.we));
	endsequence
	property p_fetch_pair;
		$rose(prog_req.req) |=>
			prog_req.addr == $past(prog_req.addr) + 13'h0001;
	endproperty
	property p_fetch_len;
		$rose(prog_req.req) |-> prog_req.req [*2] ##1 !prog_req.req;
	endproperty
	property p_done_early;
		$rose(prog_req.req) |-> !done [*8];
	endproperty
	property p_done_late;
		$rose(prog_req.req) |-> ##[LO:HI] done;
	endproperty
	property p_done_pulse;
		done |=> !done;
	endproperty
	property p_push_run;
		$rose(stk_wr.we) |-> s_push_run;
	endproperty
	property p_push_walk;
		$rose(stk_wr.we) |-> s_push_walk;
	endproperty
	property p_push_flag;
		$rose(stk_wr.we) |-> ##3 stk_wr.data[1] == 1'b0;
	endproperty
	property p_exec_pulse;
		exec_out.valid |=> !exec_out.valid && !stk_wr.we;
	endproperty
	a_fetch_pair: assert property (p_fetch_pair)
		else $error("second table byte not at next address");
	a_fetch_len: assert property (p_fetch_len)
		else $error("table fetch not two bytes");
	a_done_early: assert property (p_done_early)
		else $error("instruction ended too soon");
	a_done_late: assert property (p_done_late)
		else $error("instruction did not end in time");
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than one cycle");
	a_push_run: assert property (p_push_run)
		else $error("push run not four or five nibbles");
	a_push_walk: assert property (p_push_walk)
		else $error("push address order wrong");
	a_push_flag: assert property (p_push_flag)
		else $error("fourth push nibble bit one set");
	a_exec_pulse: assert property (p_exec_pulse)
		else $error("entry hand-over not a clean pulse");
endmodule
bind tie_table_indirect_exec tie_chk #(.MC_CLKS(MC_CLKS)) i_tie_chk (
	.hclk(hclk), .hresetn(hresetn), .prog_req(prog_req),
	.stk_wr(stk_wr), .exec_out(exec_out), .done(done));

// *** tie_far_model.sv ***
// program memory table and data memory stack model
`timescale 1ns/1ns
module tie_far_model
	import tie_pkg::*;
(
	input  wire logic          hclk,
	input  wire tie_prog_req_t prog_req,
	output logic [7:0]         prog_rdata,
	input  wire tie_stk_wr_t   stk_wr,
	output logic               exec_skip
);
	logic [7:0] rom [0:255];
	logic [3:0] stk [0:255];
	logic       skip_cfg;
	int         n_wr;
	initial begin
		prog_rdata = 8'ha5;
		skip_cfg = 1'b0;
		n_wr = 0;
	end
	// no request: inverted byte, so a stale read cannot pass
	always @(posedge hclk) begin
		prog_rdata <= prog_req.req ? rom[prog_req.addr[7:0]] : ~prog_rdata;
	end
	always @(posedge hclk) begin
		if (stk_wr.we) begin
			stk[stk_wr.addr] <= stk_wr.data;
			n_wr <= n_wr + 1;
		end
	end
	assign exec_skip = skip_cfg;
endmodule

// *** tb.sv ***
// self-checking bench for the table indirect executor
`timescale 1ns/1ns
`include "tie_map.svh"
module tb;
	import tie_pkg::*;
	logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic          exec_skip, done;
	logic [31:0]   haddr, hwdata, hrdata, rd;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [7:0]    prog_rdata;
	logic [15:0]   code_seen;
	tie_prog_req_t prog_req;
	tie_stk_wr_t   stk_wr;
	tie_exec_t     exec_out;
	int            fails, n_tests, cyc, n_jmp, n_leg, n_ext, n;
	logic [3:0]    mv [5] = '{4'h1, 4'h2, 4'hf, 4'he, 4'h0};
	logic [3:0]    me [5] = '{4'h1, 4'h1, 4'hf, 4'hf, 4'h0};
	assign hready = hreadyout;
	tie_table_indirect_exec #(.MC_CLKS(4)) i_tie_table_indirect_exec (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .prog_req(prog_req), .prog_rdata(prog_rdata),
		.stk_wr(stk_wr), .exec_out(exec_out), .exec_skip(exec_skip),
		.done(done));
	tie_far_model i_tie_far_model (
		.hclk(hclk), .prog_req(prog_req), .prog_rdata(prog_rdata),
		.stk_wr(stk_wr), .exec_skip(exec_skip));
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
	                   input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
	                    input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic sk(input logic [7:0] a, input logic [3:0] e);
		chk("stack", {28'h0, e}, {28'h0, i_tie_far_model.stk[a]});
	endtask
	task automatic st(input logic [1:0] k, input logic s);
		bus(1'b0, `TIE_OFS_STATUS, 32'h0);
		chk("kind", {30'h0, k}, {30'h0, rd[2:1]});
		chk("skip", {31'h0, s}, {31'h0, rd[3]});
	endtask
	// pc and sp are only written while idle
	task automatic run(input logic [7:0] ta, input logic [4:0] c, output int m);
		bus(1'b1, `TIE_OFS_PC, 32'h1abc);
		bus(1'b1, `TIE_OFS_SP, 32'h40);
		bus(1'b1, `TIE_OFS_TADDR, {24'h0, ta});
		bus(1'b1, `TIE_OFS_CTRL, {27'h0, c} | 32'h1);
		m = 0;
		while (done !== 1'b1 && m < 200) begin
			@(posedge hclk);
			m++;
		end
		chk("done", 32'h1, {31'h0, done});
	endtask
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (exec_out.valid === 1'b1) code_seen <= exec_out.code;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		{fails, n_tests, cyc} = '0;
		code_seen = 16'h0;
		i_tie_far_model.rom[8'h10] = 8'h1a;
		i_tie_far_model.rom[8'h11] = 8'h5c;
		i_tie_far_model.rom[8'h20] = 8'h33;
		i_tie_far_model.rom[8'h21] = 8'h47;
		i_tie_far_model.rom[8'h30] = 8'hc5;
		i_tie_far_model.rom[8'h31] = 8'h9e;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("ctrl", `TIE_OFS_CTRL, 32'h4);
		rchk("unmapped", 8'h1c, 32'h0);
		foreach (mv[i]) begin
			bus(1'b1, `TIE_OFS_MBS, {28'h0, mv[i]});
			rchk("mbs", `TIE_OFS_MBS, {28'h0, me[i]});
		end
		// bank 15 left selected, as port i/o code needs it
		bus(1'b1, `TIE_OFS_MBS, 32'hf);
		rchk("mbs", `TIE_OFS_MBS, 32'hf);
		run(8'h10, 5'h04, n_jmp);
		rchk("pc", `TIE_OFS_PC, 32'h1a5c);
		rchk("sp", `TIE_OFS_SP, 32'h40);
		chk("pushes", 32'h0, i_tie_far_model.n_wr);
		st(2'h1, 1'b0);
		run(8'h10, 5'h00, n);
		rchk("pc", `TIE_OFS_PC, 32'h0a5c);
		run(8'h20, 5'h0c, n_leg);
		rchk("pc", `TIE_OFS_PC, 32'h1347);
		rchk("sp", `TIE_OFS_SP, 32'h3c);
		sk(8'h3c, 4'ha);
		sk(8'h3f, 4'hb);
		sk(8'h3e, 4'hc);
		sk(8'h3d, 4'h9);
		st(2'h2, 1'b0);
		// 3 machine cycles of 4 clocks, seen one edge after done
		chk("leg cycles", 32'd13, n_leg);
		// register bank flag only, so a swapped flag shows
		run(8'h20, 5'h16, n_ext);
		rchk("sp", `TIE_OFS_SP, 32'h3a);
		rchk("pc", `TIE_OFS_PC, 32'h1347);
		sk(8'h3a, 4'ha);
		sk(8'h3d, 4'hb);
		sk(8'h3c, 4'hc);
		sk(8'h3b, 4'h1);
		sk(8'h3e, 4'h1);
		chk("pushes", 32'h9, i_tie_far_model.n_wr);
		chk("ext cycles", n_leg + 4, n_ext);
		chk("jump cycles", n_leg, n_jmp);
		i_tie_far_model.skip_cfg <= 1'b1;
		run(8'h30, 5'h04, n);
		chk("code", 32'hc59e, {16'h0, code_seen});
		chk("instr cycles", n_leg, n);
		rchk("entry", `TIE_OFS_ENTRY, 32'hc59e);
		st(2'h3, 1'b1);
		i_tie_far_model.skip_cfg <= 1'b0;
		run(8'h30, 5'h04, n);
		st(2'h3, 1'b0);
		stop_test();
	end
endmodule
